// file: asr_pkg.sv
// Shared constants and types for the serial result readout link.
// Assumes a 250 MHz system clock on both ends.
package asr_pkg;

    // ------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------
    localparam int RES_BITS = 16;
    localparam int FRAME_BITS = 17;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] LIMIT_PLAIN = 5'h10;
    localparam logic [CNT_W-1:0] LIMIT_BUSY = 5'h11;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int MCLK_NS = 4;
    localparam int CONV_NS = 1200;
    localparam int CONV_CYC = (CONV_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int QUIET_BEFORE_NS = 30;
    localparam int QUIET_AFTER_NS = 10;
    localparam int QUIET_BEFORE_CYC = (QUIET_BEFORE_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int QUIET_AFTER_CYC = (QUIET_AFTER_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int SCLK_HALF_CYC = 6;
    localparam int TMR_W = 12;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {DEV_IDLE, DEV_CONV, DEV_READY} asr_dev_e;
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_RISE, H_WAIT, H_SHIFT, H_END} asr_host_e;
    typedef enum logic [1:0] {MODE_CS_BUSY, MODE_CHAIN, MODE_CHAIN_BUSY} asr_mode_e;

endpackage

// file: asr_link_if.sv
// Link between the converter end and the host end.
// Assumes a pull-up on the serial output wire, resolved here.
`timescale 1ns/1ps
interface asr_link_if;
    logic convert_start;
    logic serial_data_in_select;
    logic sclk;
    logic sdoOut;
    logic sdoOe;
    logic serial_data_out;

    // Pull-up holds the wire high while nobody drives it
    assign serial_data_out = sdoOe ? sdoOut : 1'b1;

    modport dev (
        input convert_start,
        input serial_data_in_select,
        input sclk,
        output sdoOut,
        output sdoOe
    );

    modport host (
        output convert_start,
        output serial_data_in_select,
        output sclk,
        input serial_data_out
    );
endinterface

// file: asr_dev.sv
// Converter end of the serial readout link: mode capture, conversion
// timing and the serial output shift register.
// Assumes the host keeps the link quiet while results are reloaded.
`timescale 1ns/1ps

module asr_dev
    import asr_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    asr_link_if.dev link,
    input wire logic [RES_BITS-1:0] sampleIn,
    output logic convDone,
    output logic [RES_BITS-1:0] lastResult
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 3;
    // Select idles high, so its stages reset high to avoid a false deselect
    localparam logic [NSYNC-1:0] PIN_IDLE = 3'h2;
    logic [NSYNC-1:0] pinRaw;
    logic [NSYNC-1:0] syncA_r;
    logic [NSYNC-1:0] syncB_r;
    logic cnvS;
    logic sdiS;
    logic sclkS;

    assign pinRaw = {link.sclk, link.serial_data_in_select, link.convert_start};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    syncA_r[gi] <= PIN_IDLE[gi];
                    syncB_r[gi] <= PIN_IDLE[gi];
                end else begin
                    syncA_r[gi] <= pinRaw[gi];
                    syncB_r[gi] <= syncA_r[gi];
                end
            end
        end
    endgenerate

    assign cnvS = syncB_r[0];
    assign sdiS = syncB_r[1];
    assign sclkS = syncB_r[2];

    logic cnvPrev_r;
    logic sdiPrev_r;
    logic cnvRise;
    logic sdiRise;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnvPrev_r <= 1'b0;
            sdiPrev_r <= 1'b1;
        end else begin
            cnvPrev_r <= cnvS;
            sdiPrev_r <= sdiS;
        end
    end

    assign cnvRise = cnvS & ~cnvPrev_r;
    assign sdiRise = sdiS & ~sdiPrev_r;

    // ------------------------------------------------------------
    // Mode capture and conversion sequencing
    // ------------------------------------------------------------
    asr_dev_e state_r;
    logic [TMR_W-1:0] convCnt_r;
    logic csMode_r;
    logic busyEn_r;
    logic csEnd_r;
    logic shiftClr_r;
    logic [RES_BITS-1:0] sample_r;
    logic [FRAME_BITS-1:0] word_r;
    logic convEnd;

    assign convEnd = (state_r == DEV_CONV) && (convCnt_r == TMR_W'(CONV_CYCLES - 1));

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= DEV_IDLE;
            convCnt_r <= '0;
            csMode_r <= 1'b0;
            busyEn_r <= 1'b0;
        end else if (cnvRise) begin
            state_r <= DEV_CONV;
            convCnt_r <= '0;
            csMode_r <= sdiS;
            busyEn_r <= ~sdiS & sclkS;
        end else begin
            case (state_r)
                DEV_CONV: begin
                    convCnt_r <= convCnt_r + TMR_W'(1);
                    if (convEnd) begin
                        state_r <= DEV_READY;
                        if (csMode_r) begin
                            busyEn_r <= ~sdiS;
                        end
                    end
                end
                default: begin
                    convCnt_r <= convCnt_r;
                end
            endcase
        end
    end

    // Result word: a leading busy bit in busy modes, else the MSB on top
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sample_r <= '0;
            word_r <= '0;
            lastResult <= '0;
        end else if (cnvRise) begin
            sample_r <= sampleIn;
        end else if (convEnd) begin
            lastResult <= sample_r;
            if (csMode_r && !sdiS) begin
                word_r <= {1'b0, sample_r};
            end else if (!csMode_r && busyEn_r) begin
                word_r <= {1'b1, sample_r};
            end else begin
                word_r <= {sample_r, 1'b0};
            end
        end
    end

    // Holds the link-side shifter cleared until a result is ready
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            shiftClr_r <= 1'b1;
            convDone <= 1'b0;
        end else begin
            convDone <= convEnd;
            if (cnvRise) begin
                shiftClr_r <= 1'b1;
            end else if (convEnd) begin
                shiftClr_r <= 1'b0;
            end
        end
    end

    // Select rising ends a chip-select readout
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            csEnd_r <= 1'b0;
        end else if (cnvRise) begin
            csEnd_r <= 1'b0;
        end else if (state_r == DEV_READY && csMode_r && sdiRise) begin
            csEnd_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Output drive control
    // ------------------------------------------------------------
    logic drv_r;
    logic showData_r;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            drv_r <= 1'b0;
            showData_r <= 1'b0;
        end else if (!cnvS && !sdiS) begin
            drv_r <= 1'b1;
            showData_r <= 1'b0;
        end else if (cnvRise) begin
            // Hide the old word at once, or it flashes out as a false busy bit
            drv_r <= ~sdiS;
            showData_r <= 1'b0;
        end else begin
            case (state_r)
                DEV_CONV: begin
                    drv_r <= ~csMode_r;
                    showData_r <= 1'b0;
                end
                DEV_READY: begin
                    if (csMode_r) begin
                        drv_r <= ~sdiS & ~csEnd_r;
                    end else begin
                        drv_r <= 1'b1;
                    end
                    showData_r <= 1'b1;
                end
                default: begin
                    drv_r <= 1'b0;
                    showData_r <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Link-side shift register
    // ------------------------------------------------------------
    // Busy modes shift the full frame; plain modes skip the spare low bit
    function automatic logic [FRAME_BITS-1:0] shift_in(
        input logic [FRAME_BITS-1:0] v,
        input logic busy,
        input logic s
    );
        logic [FRAME_BITS-1:0] r;
        if (busy) begin
            r = {v[FRAME_BITS-2:0], s};
        end else begin
            r = {v[FRAME_BITS-2:1], s, 1'b0};
        end
        return r;
    endfunction

    logic [FRAME_BITS-1:0] sh_r;
    logic [CNT_W-1:0] bitCnt_r;
    logic linkClr;
    logic [CNT_W-1:0] limit;
    logic shDone;
    logic outBit;

    // Clear is a flop output ORed with the reset, so it is glitch free; sclk is idle at release
    assign linkClr = shiftClr_r | ~rst_b;
    assign limit = busyEn_r ? LIMIT_BUSY : LIMIT_PLAIN;
    assign shDone = (bitCnt_r >= limit);

    // word_r is stable from the clear release until the next conversion
    always_ff @(negedge link.sclk or posedge linkClr) begin
        if (linkClr) begin
            sh_r <= '0;
            bitCnt_r <= CNT_ZERO;
        end else begin
            if (bitCnt_r == CNT_ZERO) begin
                sh_r <= shift_in(word_r, busyEn_r, link.serial_data_in_select);
            end else begin
                sh_r <= shift_in(sh_r, busyEn_r, link.serial_data_in_select);
            end
            if (!shDone) begin
                bitCnt_r <= bitCnt_r + CNT_ONE;
            end
        end
    end

    assign outBit = (bitCnt_r == CNT_ZERO) ? word_r[FRAME_BITS-1] : sh_r[FRAME_BITS-1];

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    assign link.sdoOe = drv_r & ~(csMode_r & shDone & showData_r);
    assign link.sdoOut = showData_r & outBit;

endmodule

// file: asr_host.sv
// Host end of the serial readout link: starts a conversion in the
// chosen mode, waits for completion and clocks the results in.
// Assumes one converter, or a chain of N_DEV converters, on the link.
`timescale 1ns/1ps
module asr_host
    import asr_pkg::*;
#(
    parameter int N_DEV = 1,
    parameter int CONV_WAIT = CONV_CYC + 4,
    parameter int HALF = SCLK_HALF_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    asr_link_if.host link,
    input wire logic start,
    input wire asr_mode_e mode,
    output logic busy,
    output logic rxValid,
    output logic [RES_BITS*N_DEV-1:0] rxData
);

    localparam int RX_W = RES_BITS * N_DEV;
    localparam int EDGE_W = $clog2(RX_W + 2);

    // ------------------------------------------------------------
    // Serial output synchroniser
    // ------------------------------------------------------------
    logic sdoA_r;
    logic sdoS_r;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sdoA_r <= 1'b1;
            sdoS_r <= 1'b1;
        end else begin
            sdoA_r <= link.serial_data_out;
            sdoS_r <= sdoA_r;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    asr_host_e state_r;
    asr_mode_e mode_r;
    logic [TMR_W-1:0] tmr_r;
    logic [EDGE_W-1:0] edges_r;
    logic [RX_W-1:0] rx_r;
    logic cnv_r;
    logic sdi_r;
    logic sclk_r;
    logic tmrEnd;
    logic busyMode;

    assign tmrEnd = (tmr_r == '0);
    assign busyMode = (mode_r != MODE_CHAIN);
    assign link.convert_start = cnv_r;
    assign link.serial_data_in_select = sdi_r;
    assign link.sclk = sclk_r;
    assign busy = (state_r != H_IDLE);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= H_IDLE;
            mode_r <= MODE_CS_BUSY;
            tmr_r <= '0;
            edges_r <= '0;
            rx_r <= '0;
            cnv_r <= 1'b0;
            sdi_r <= 1'b1;
            sclk_r <= 1'b0;
            rxValid <= 1'b0;
            rxData <= '0;
        end else begin
            rxValid <= 1'b0;
            if (!tmrEnd) begin
                tmr_r <= tmr_r - TMR_W'(1);
            end
            case (state_r)
                H_IDLE: begin
                    if (start) begin
                        mode_r <= mode;
                        sdi_r <= (mode == MODE_CS_BUSY);
                        sclk_r <= (mode == MODE_CHAIN_BUSY);
                        tmr_r <= TMR_W'(QUIET_BEFORE_CYC);
                        state_r <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    if (tmrEnd) begin
                        cnv_r <= 1'b1;
                        tmr_r <= TMR_W'(QUIET_AFTER_CYC);
                        state_r <= H_RISE;
                    end
                end
                H_RISE: begin
                    if (tmrEnd) begin
                        sdi_r <= 1'b0;
                        sclk_r <= 1'b0;
                        tmr_r <= TMR_W'(CONV_WAIT);
                        state_r <= H_WAIT;
                    end
                end
                H_WAIT: begin
                    // Busy modes wait for the indicator, plain mode for the timer
                    if ((mode_r == MODE_CS_BUSY && !sdoS_r && tmr_r < TMR_W'(CONV_WAIT - 4))
                        || (mode_r == MODE_CHAIN_BUSY && sdoS_r)
                        || (mode_r == MODE_CHAIN && tmrEnd)) begin
                        edges_r <= busyMode ? EDGE_W'(RX_W + 1)
                                            : EDGE_W'(RX_W);
                        tmr_r <= TMR_W'(HALF - 1);
                        state_r <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (tmrEnd) begin
                        tmr_r <= TMR_W'(HALF - 1);
                        if (sclk_r) begin
                            // Sample just before the falling edge
                            rx_r <= {rx_r[RX_W-2:0], sdoS_r};
                            sclk_r <= 1'b0;
                            edges_r <= edges_r - EDGE_W'(1);
                        end else if (edges_r == '0) begin
                            state_r <= H_END;
                        end else begin
                            sclk_r <= 1'b1;
                        end
                    end
                end
                H_END: begin
                    cnv_r <= 1'b0;
                    sdi_r <= (mode_r == MODE_CS_BUSY);
                    rxData <= rx_r;
                    rxValid <= 1'b1;
                    state_r <= H_IDLE;
                end
                default: begin
                    state_r <= H_IDLE;
                end
            endcase
        end
    end

endmodule

// file: asr_link_properties.sv
// Checker for the readout link: timing relations between both ends.
// Assumes one converter on the link and the host driving all requests.
`timescale 1ns/1ps
module asr_link_properties (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic convert_start,
    input wire logic serial_data_in_select,
    input wire logic sclk,
    input wire logic sdoOut,
    input wire logic sdoOe,
    input wire logic serial_data_out
);
    // ------------------------------------------------------------
    // Frame tracking
    // ------------------------------------------------------------
    localparam int ARM_AT = 8;
    logic cnvPrev_r;
    logic sclkPrev_r;
    logic csMode_r;
    logic chainBusy_r;
    logic [5:0] armCnt_r;
    logic [4:0] fallCnt_r;
    logic armed;
    assign armed = armCnt_r > 6'(ARM_AT);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnvPrev_r <= 1'b0;
            sclkPrev_r <= 1'b0;
        end else begin
            cnvPrev_r <= convert_start;
            sclkPrev_r <= sclk;
        end
    end

    // Mode as seen at the convert rise; counts restart there
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            csMode_r <= 1'b0;
            chainBusy_r <= 1'b0;
            armCnt_r <= 6'h00;
            fallCnt_r <= 5'h00;
        end else if (convert_start && !cnvPrev_r) begin
            csMode_r <= serial_data_in_select;
            chainBusy_r <= !serial_data_in_select && sclk;
            armCnt_r <= 6'h00;
            fallCnt_r <= 5'h00;
        end else begin
            if (armCnt_r != 6'h3f) begin
                armCnt_r <= armCnt_r + 6'h01;
            end
            if (armed && sclkPrev_r && !sclk && fallCnt_r != 5'h1f) begin
                fallCnt_r <= fallCnt_r + 5'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sel_low_drive_a: assert property (
        (!convert_start && !serial_data_in_select)[*4] |-> sdoOe && !sdoOut)
        else $error("output not driven low while deselected");
    cs_hiz_conv_a: assert property (
        $rose(convert_start) && serial_data_in_select |-> ##5 (!sdoOe)[*8])
        else $error("output driven during chip-select conversion");
    quiet_edge_a: assert property (
        $rose(convert_start) |-> ($past(serial_data_in_select, 6) == serial_data_in_select) && ($past(sclk, 6) == sclk)
            ##1 ($stable(serial_data_in_select) && $stable(sclk))[*2])
        else $error("link pins moved near convert rise");
    cs_busy_low_a: assert property (
        $fell(sclk) && csMode_r && armed && fallCnt_r == 5'h00 |-> $past(sdoOe) && !$past(sdoOut))
        else $error("no driven low busy bit in chip-select mode");
    chain_busy_high_a: assert property (
        $fell(sclk) && chainBusy_r && armed && fallCnt_r == 5'h00 |-> $past(sdoOe) && $past(sdoOut))
        else $error("no high busy bit in chain mode");
    bit_stable_a: assert property (
        sclk && $past(sclk) && sdoOe && $past(sdoOe) |-> $stable(sdoOut))
        else $error("data bit changed while shift clock high");
    cs_lsb_held_a: assert property (
        csMode_r && armed && fallCnt_r == 5'h10 && sclk && convert_start && !serial_data_in_select |-> sdoOe)
        else $error("output released before the last edge");
    cs_release_a: assert property (
        csMode_r && fallCnt_r == 5'h11 && $past(fallCnt_r) == 5'h10 |-> ##4 !sdoOe)
        else $error("output not released after the last edge");
    hold_cnv_a: assert property (
        $fell(sclk) && armed |-> convert_start)
        else $error("convert low during readback");
    count_a: assert property (
        $fell(convert_start) && armed |-> fallCnt_r == ((csMode_r || chainBusy_r) ? 5'h11 : 5'h10))
        else $error("wrong number of shift clocks in frame");
    sel_early_a: assert property (
        csMode_r && armCnt_r == 6'h08 |-> !serial_data_in_select && convert_start)
        else $error("select not lowered early for busy");
    wire_level_a: assert property (
        sdoOe |-> serial_data_out == sdoOut)
        else $error("link wire differs from the driven bit");
endmodule

// file: tb.sv
// Testbench: host and converter ends face each other on one link;
// a second converter is driven directly by the bench on a second link.
`timescale 1ns/1ps
module tb;
    import asr_pkg::*;
    localparam int CONV_SMALL = 20;
    logic mclk;
    logic rst_b;
    logic start;
    asr_mode_e mode;
    logic [RES_BITS-1:0] sampleIn;
    logic [RES_BITS-1:0] sampleB;
    logic hostBusy;
    logic rxValid;
    logic convDone;
    logic convDoneB;
    logic [RES_BITS-1:0] rxData;
    logic [RES_BITS-1:0] lastResult;
    logic [RES_BITS-1:0] lastResultB;
    int bad_count;
    int compares;

    asr_link_if link();
    asr_link_if linkB();
    asr_dev #(.CONV_CYCLES(CONV_SMALL)) u_asr_dev (.mclk(mclk), .rst_b(rst_b), .link(link.dev),
        .sampleIn(sampleIn), .convDone(convDone), .lastResult(lastResult));
    asr_dev #(.CONV_CYCLES(CONV_SMALL)) u_asr_dev_b (.mclk(mclk), .rst_b(rst_b),
        .link(linkB.dev), .sampleIn(sampleB), .convDone(convDoneB), .lastResult(lastResultB));
    asr_host #(.N_DEV(1), .CONV_WAIT(CONV_SMALL + 4)) u_asr_host (.mclk(mclk), .rst_b(rst_b),
        .link(link.host), .start(start), .mode(mode), .busy(hostBusy), .rxValid(rxValid),
        .rxData(rxData));
    asr_link_properties u_props (.mclk(mclk), .rst_b(rst_b), .convert_start(link.convert_start), .serial_data_in_select(link.serial_data_in_select),
        .sclk(link.sclk), .sdoOut(link.sdoOut), .sdoOe(link.sdoOe), .serial_data_out(link.serial_data_out));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic host_frame(input asr_mode_e m, input logic [15:0] s);
        int i;
        int pulses;
        pulses = 0;
        sampleIn = s;
        mode = m;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        check("host busy", hostBusy, 1);
        for (i = 0; i < 1000 && rxValid !== 1'b1; i++) begin
            if (convDone === 1'b1) pulses++;
            tick(1);
        end
        if (rxValid !== 1'b1) begin
            check("rxValid timeout", 0, 1);
            close_out();
        end
        check("rxData", rxData, s);
        check("host done", hostBusy, 0);
        check("lastResult", lastResult, s);
        check("convDone pulses", pulses, 1);
        tick(10);
    endtask

    // Chip-select with busy; select rises after stopAt edges when below 17
    task automatic b_cs_busy(input logic [15:0] s, input int stopAt);
        int i;
        int pulses;
        pulses = 0;
        linkB.serial_data_in_select = 1'b1;
        linkB.sclk = 1'b0;
        linkB.convert_start = 1'b0;
        sampleB = s;
        tick(10);
        linkB.convert_start = 1'b1;
        tick(5);
        check("cs oe at start", linkB.sdoOe, 0);
        linkB.serial_data_in_select = 1'b0;
        for (i = 0; i < CONV_SMALL + 10; i++) begin
            tick(1);
            if (convDoneB === 1'b1) pulses++;
        end
        check("cs done pulses", pulses, 1);
        check("cs busy oe", linkB.sdoOe, 1);
        check("cs busy bit", linkB.serial_data_out, 0);
        check("cs result", lastResultB, s);
        for (i = 0; i < stopAt; i++) begin
            linkB.sclk = 1'b1;
            tick(6);
            check("cs bit", linkB.serial_data_out, (i == 0) ? 1'b0 : s[16-i]);
            linkB.sclk = 1'b0;
            tick(6);
        end
        if (stopAt < 17) linkB.serial_data_in_select = 1'b1;
        tick(5);
        check("cs release", linkB.sdoOe, 0);
        linkB.convert_start = 1'b0;
        tick(5);
    endtask

    // Chain mode, with or without busy bit; upstream word fed on select
    task automatic b_chain(input logic [15:0] s, input logic [15:0] up, input int busyOn);
        int i;
        int len;
        logic expBit;
        len = 16 + busyOn;
        linkB.serial_data_in_select = 1'b0;
        linkB.sclk = busyOn[0];
        linkB.convert_start = 1'b0;
        sampleB = s;
        tick(4);
        check("deselected oe", linkB.sdoOe, 1);
        check("deselected level", linkB.serial_data_out, 0);
        tick(6);
        linkB.convert_start = 1'b1;
        tick(4);
        linkB.sclk = 1'b0;
        tick(CONV_SMALL + 10);
        for (i = 0; i < len + 16; i++) begin
            if (i < 16) linkB.serial_data_in_select = up[15-i];
            if (i < len) expBit = (busyOn == 1 && i == 0) ? 1'b1 : s[15-(i-busyOn)];
            else expBit = up[15-(i-len)];
            check("chain oe", linkB.sdoOe, 1);
            check("chain bit", linkB.serial_data_out, expBit);
            linkB.sclk = 1'b1;
            tick(6);
            linkB.sclk = 1'b0;
            tick(6);
        end
        linkB.convert_start = 1'b0;
        linkB.serial_data_in_select = 1'b1;
        tick(5);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        asr_mode_e modeTab[3];
        logic [15:0] sampTab[3];
        int k;
        modeTab = '{MODE_CS_BUSY, MODE_CHAIN, MODE_CHAIN_BUSY};
        sampTab = '{16'ha5c3, 16'h8001, 16'h7ffe};
        bad_count = 0;
        compares = 0;
        rst_b = 1'b0;
        start = 1'b0;
        mode = MODE_CS_BUSY;
        sampleIn = 16'h0000;
        sampleB = 16'h0000;
        linkB.convert_start = 1'b0;
        linkB.serial_data_in_select = 1'b1;
        linkB.sclk = 1'b0;
        tick(2);
        rst_b = 1'b1;
        tick(3);
        check("host idle", hostBusy, 0);
        check("rx idle", rxValid, 0);
        for (k = 0; k < 3; k++) begin
            host_frame(modeTab[k], sampTab[k]);
        end
        b_cs_busy(16'hc35a, 17);
        b_cs_busy(16'h3cf0, 5);
        b_chain(16'hb2e1, 16'h4d17, 0);
        b_chain(16'h1e87, 16'h9a62, 1);
        close_out();
    end
endmodule
